// >>> core/flexible_operand_barrel_shifter.v
`default_nettype none

module flexible_operand_barrel_shifter
(
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst_b,
	// operand request from the decoder
	input  wire        i_op_valid,
	input  wire        i_use_imm,
	input  wire        i_set_flags,
	input  wire        i_logic_class,
	// constant form
	input  wire [7:0]  i_imm_byte,
	input  wire [1:0]  i_imm_form,
	input  wire [4:0]  i_imm_lsl,
	// register form
	input  wire [31:0] i_shift_source_reg,
	input  wire [2:0]  i_shift_kind,
	input  wire [7:0]  i_shift_amt,
	input  wire        i_amt_is_imm,
	// carry written by the ALU for arithmetic ops
	input  wire        i_alu_carry_we,
	input  wire        i_alu_carry,
	// program counter target check
	input  wire        i_pc_write,
	input  wire [31:0] i_pc_target,
	// operand to the ALU
	output wire [31:0] o_flexible_second_input,
	output wire        o_shift_carry,
	output wire        o_shift_carry_upd,
	output wire        o_amt_illegal,
	// carry flag
	output wire        o_carry_flag,
	// program counter target
	output wire [31:0] o_pc_addr,
	output wire        o_isa_fault
);

`include "operand_defs.vh"

	// checks an immediate shift amount against the range of its kind
	function amt_ok;
		input [2:0] kind;
		input [7:0] amt;
		begin
			if (kind == `SHIFT_RRX)
				amt_ok = 1'b1;
			else if ((kind == `SHIFT_LSL) && (amt == 8'h00))
				amt_ok = 1'b1;
			else if ((kind == `SHIFT_LSR) || (kind == `SHIFT_ASR))
				amt_ok = (amt >= `IMM_AMT_MIN) && (amt <= `IMM_AMT_MAX_RS);
			else
				amt_ok = (amt >= `IMM_AMT_MIN) && (amt <= `IMM_AMT_MAX_LR);
		end
	endfunction

	reg         carry_r;
	reg         carry_nxt;

	wire [31:0] imm_value;
	wire        imm_carry_upd;
	wire        imm_carry;
	wire [31:0] sh_result;
	wire        sh_carry;
	wire        sh_carry_upd;
	wire        sel_carry_upd;
	wire        sel_carry;

	imm_expander u_imm
	(
		.i_imm_byte      (i_imm_byte),
		.i_imm_form      (i_imm_form),
		.i_imm_lsl       (i_imm_lsl),
		.o_imm_value     (imm_value),
		.o_imm_carry_upd (imm_carry_upd),
		.o_imm_carry     (imm_carry)
	);

	// the shifter sees a copy; the source register file is never written here
	barrel_shift u_shift
	(
		.i_src       (i_shift_source_reg),
		.i_kind      (i_shift_kind),
		.i_amt       (i_shift_amt),
		.i_carry_in  (carry_r),
		.o_result    (sh_result),
		.o_carry     (sh_carry),
		.o_carry_upd (sh_carry_upd)
	);

	// combinational so the ALU consumes it in the same cycle
	assign o_flexible_second_input = i_use_imm ? imm_value : sh_result;
	assign sel_carry_upd           = i_use_imm ? imm_carry_upd : sh_carry_upd;
	assign sel_carry               = i_use_imm ? imm_carry : sh_carry;
	assign o_shift_carry           = sel_carry_upd ? sel_carry : carry_r;
	assign o_shift_carry_upd       = i_op_valid & i_set_flags & i_logic_class & sel_carry_upd;

	// amounts taken from a register may be anything; only encoded ones are bounded
	assign o_amt_illegal = i_op_valid & ~i_use_imm & i_amt_is_imm
		& ~amt_ok(i_shift_kind, i_shift_amt);

	// shifter carry wins over the ALU; the two never come from one instruction
	always @*
	begin
		carry_nxt = carry_r;
		if (o_shift_carry_upd)
			carry_nxt = sel_carry;
		else if (i_alu_carry_we)
			carry_nxt = i_alu_carry;
	end

	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			carry_r <= `CARRY_RST;
		else
			carry_r <= carry_nxt;
	end

	assign o_carry_flag = carry_r;

	// bit 0 only names the instruction set and is stripped from the address
	assign o_pc_addr   = {i_pc_target[31:1], 1'b0};
	assign o_isa_fault = i_pc_write & ~i_pc_target[0];

endmodule // flexible_operand_barrel_shifter

`default_nettype wire

// >>> core/operand_defs.vh
`ifndef OPERAND_DEFS_VH
`define OPERAND_DEFS_VH

// shift kinds on i_shift_kind
`define SHIFT_LSL        3'h0
`define SHIFT_LSR        3'h1
`define SHIFT_ASR        3'h2
`define SHIFT_ROR        3'h3
`define SHIFT_RRX        3'h4

// immediate forms on i_imm_form
`define IMM_FORM_SHIFTED 2'h0
`define IMM_FORM_B0B2    2'h1
`define IMM_FORM_B1B3    2'h2
`define IMM_FORM_ALL     2'h3

// bounds of a shift amount given as an immediate
`define IMM_AMT_MIN      8'h01
`define IMM_AMT_MAX_RS   8'h20
`define IMM_AMT_MAX_LR   8'h1F

// word size and limits
`define WORD_SHIFT       8'h20
`define WORD_SHIFT_PLUS1 8'h21
`define IMM_PLAIN_MAX    32'h000000FF

// reset value of the carry flag
`define CARRY_RST        1'b0

`endif

// >>> core/imm_expander.v
`default_nettype none

module imm_expander
(
	// encoded constant
	input  wire [7:0]  i_imm_byte,
	input  wire [1:0]  i_imm_form,
	input  wire [4:0]  i_imm_lsl,
	// expanded constant
	output reg  [31:0] o_imm_value,
	output reg         o_imm_carry_upd,
	output reg         o_imm_carry
);

`include "operand_defs.vh"

	reg [31:0] shifted;

	always @*
	begin
		shifted         = {24'h000000, i_imm_byte} << i_imm_lsl;
		o_imm_carry_upd = 1'b0;
		o_imm_carry     = 1'b0;
		case (i_imm_form)
			`IMM_FORM_SHIFTED:
			begin
				o_imm_value = shifted;
				// only a shifted constant above one byte touches carry
				o_imm_carry_upd = (shifted > `IMM_PLAIN_MAX);
				o_imm_carry     = shifted[31];
			end
			`IMM_FORM_B0B2:
				o_imm_value = {8'h00, i_imm_byte, 8'h00, i_imm_byte};
			`IMM_FORM_B1B3:
				o_imm_value = {i_imm_byte, 8'h00, i_imm_byte, 8'h00};
			default:
				o_imm_value = {i_imm_byte, i_imm_byte, i_imm_byte, i_imm_byte};
		endcase
	end

endmodule // imm_expander

`default_nettype wire

// >>> core/barrel_shift.v
`default_nettype none

module barrel_shift
(
	// operand and shift
	input  wire [31:0] i_src,
	input  wire [2:0]  i_kind,
	input  wire [7:0]  i_amt,
	input  wire        i_carry_in,
	// result
	output reg  [31:0] o_result,
	output reg         o_carry,
	output reg         o_carry_upd
);

`include "operand_defs.vh"

	// picks one bit of the source by a 5-bit index
	function bit_at;
		input [31:0] v;
		input [4:0]  idx;
		reg   [31:0] t;
		begin
			t      = v >> idx;
			bit_at = t[0];
		end
	endfunction

	reg [63:0] rot;
	reg [4:0]  amt5;
	reg [4:0]  amt5_m1;
	reg [4:0]  lsl_idx;

	always @*
	begin
		amt5        = i_amt[4:0];
		amt5_m1     = amt5 - 5'h01;
		lsl_idx     = 5'h00 - amt5;
		rot         = {i_src, i_src} >> amt5;
		o_result    = i_src;
		o_carry     = i_carry_in;
		// zero length keeps source and carry alike for every kind but RRX, which ignores the amount
		o_carry_upd = (i_amt != 8'h00);
		case (i_kind)
			`SHIFT_LSR:
				if (i_amt == 8'h00)
					o_result = i_src;
				else if (i_amt < `WORD_SHIFT)
				begin
					o_result = i_src >> amt5;
					o_carry  = bit_at(i_src, amt5_m1);
				end
				else
				begin
					o_result = 32'h00000000;
					o_carry  = (i_amt == `WORD_SHIFT) ? i_src[31] : 1'b0;
				end
			`SHIFT_ASR:
				if (i_amt == 8'h00)
					o_result = i_src;
				else if (i_amt < `WORD_SHIFT)
				begin
					o_result = $signed(i_src) >>> amt5;
					o_carry  = bit_at(i_src, amt5_m1);
				end
				else
				begin
					o_result = {32{i_src[31]}};
					o_carry  = i_src[31];
				end
			`SHIFT_ROR:
				if (i_amt == 8'h00)
					o_result = i_src;
				else if (amt5 == 5'h00)
				begin
					// any multiple of 32 folds down to the full turn
					o_result = i_src;
					o_carry  = i_src[31];
				end
				else
				begin
					o_result = rot[31:0];
					o_carry  = bit_at(i_src, amt5_m1);
				end
			`SHIFT_RRX:
			begin
				o_result    = {i_carry_in, i_src[31:1]};
				o_carry     = i_src[0];
				o_carry_upd = 1'b1;
			end
			default:
				if (i_amt == 8'h00)
					o_result = i_src;
				else if (i_amt < `WORD_SHIFT)
				begin
					o_result = i_src << amt5;
					o_carry  = bit_at(i_src, lsl_idx);
				end
				else
				begin
					o_result = 32'h00000000;
					o_carry  = (i_amt == `WORD_SHIFT) ? i_src[0] : 1'b0;
				end
		endcase
	end

endmodule // barrel_shift

`default_nettype wire

// >>> sim/alu_side.sv
`default_nettype none
// ALU side: arithmetic ops write the carry at random moments
module alu_side
(
	// clock
	input  wire logic i_clk,
	input  wire logic i_en,
	// carry write
	output var  logic o_we = 1'b0,
	output var  logic o_carry = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge i_clk)
	begin
		o_we    <= i_en & ($urandom_range(0, 3) == 0);
		o_carry <= 1'($urandom_range(0, 1));
	end
endmodule // alu_side
`default_nettype wire

// >>> sim/operand_assertions.sv
`default_nettype none
module operand_checker
(
	// watched ports
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic        i_op_valid,
	input wire logic        i_use_imm,
	input wire logic [31:0] i_shift_source_reg,
	input wire logic [2:0]  i_shift_kind,
	input wire logic [7:0]  i_shift_amt,
	input wire logic        i_alu_carry_we,
	input wire logic        i_pc_write,
	input wire logic [31:0] i_pc_target,
	input wire logic [31:0] o_flexible_second_input,
	input wire logic        o_shift_carry,
	input wire logic        o_shift_carry_upd,
	input wire logic        o_carry_flag,
	input wire logic        o_isa_fault
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic rf = i_op_valid & ~i_use_imm;
	sequence s_upd;
		o_shift_carry_upd;
	endsequence
	sequence s_take;
		o_carry_flag == $past(o_shift_carry);
	endsequence
	AST_CARRY_TAKE: assert property (s_upd |=> s_take) else $error("carry flag missed carry out");
	AST_CARRY_HOLD: assert property (!o_shift_carry_upd && !i_alu_carry_we |=> $stable(o_carry_flag))
		else $error("carry flag moved");
	AST_PASS: assert property (rf && i_shift_kind == 3'h0 && i_shift_amt == 8'h00
		|-> o_flexible_second_input == i_shift_source_reg) else $error("source not passed");
	AST_ZERO_KEEP: assert property (rf && i_shift_kind != 3'h4 && i_shift_amt == 8'h00
		|-> !o_shift_carry_upd) else $error("zero length touched carry");
	AST_LOGIC_BIG: assert property (rf && i_shift_kind <= 3'h1 && i_shift_amt >= 8'h20
		|-> o_flexible_second_input == 32'h0) else $error("long logical shift not zero");
	AST_SIGN_FILL: assert property (rf && i_shift_kind == 3'h2 && i_shift_amt >= 8'h20
		|-> o_flexible_second_input == {32{i_shift_source_reg[31]}}) else $error("sign fill wrong");
	AST_ROT32: assert property (rf && i_shift_kind == 3'h3 && i_shift_amt == 8'h20
		|-> o_flexible_second_input == i_shift_source_reg) else $error("rotate by word wrong");
	AST_ISA: assert property (i_pc_write && !i_pc_target[0] |-> o_isa_fault) else $error("fault missed");
endmodule // operand_checker
bind flexible_operand_barrel_shifter operand_checker u_chk (.i_clk, .i_rst_b, .i_op_valid, .i_use_imm,
	.i_shift_source_reg, .i_shift_kind, .i_shift_amt, .i_alu_carry_we, .i_pc_write, .i_pc_target,
	.o_flexible_second_input, .o_shift_carry, .o_shift_carry_upd, .o_carry_flag, .o_isa_fault);
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_rst_b, i_op_valid, i_use_imm, i_set_flags, i_logic_class;
	logic        i_amt_is_imm, i_alu_carry_we, i_alu_carry, i_pc_write;
	logic [7:0]  i_imm_byte, i_shift_amt;
	logic [1:0]  i_imm_form;
	logic [4:0]  i_imm_lsl;
	logic [2:0]  i_shift_kind;
	logic [31:0] i_shift_source_reg, i_pc_target, o_flexible_second_input, o_pc_addr;
	logic        o_shift_carry, o_shift_carry_upd, o_amt_illegal, o_carry_flag, o_isa_fault;
	logic        mc, nx;
	int          bad_count, samples_checked, cyc;
	int          amts[8] = '{0, 1, 31, 32, 33, 64, 65, 255};
	flexible_operand_barrel_shifter dut (.i_clk, .i_rst_b, .i_op_valid, .i_use_imm, .i_set_flags,
		.i_logic_class, .i_imm_byte, .i_imm_form, .i_imm_lsl, .i_shift_source_reg, .i_shift_kind,
		.i_shift_amt, .i_amt_is_imm, .i_alu_carry_we, .i_alu_carry, .i_pc_write, .i_pc_target,
		.o_flexible_second_input, .o_shift_carry, .o_shift_carry_upd, .o_amt_illegal, .o_carry_flag,
		.o_pc_addr, .o_isa_fault);
	alu_side u_alu (.i_clk, .i_en(i_rst_b), .o_we(i_alu_carry_we), .o_carry(i_alu_carry));
	function automatic logic [32:0] shf(logic [31:0] s, int k, int n, logic c);
		logic [63:0] w;
		int m;
		m = (n - 1) % 32 + 1;
		w = {s, s} >> m;
		if (k != 4 && n == 0)
			return {c, s};
		case (k)
			1: return (n > 32) ? 33'h0 : {s[n-1], s >> n};
			2: return (n > 31) ? {33{s[31]}} : {s[n-1], 32'($signed(s) >>> n)};
			3: return {s[m-1], w[31:0]};
			4: return {s[0], c, s[31:1]};
			default: return (n > 32) ? 33'h0 : {s[32-n], s << n};
		endcase
	endfunction
	task automatic chk(string nm, logic [32:0] got, logic [32:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic step(int md);
		logic [32:0] e;
		logic        u;
		logic        g;
		int          lim;
		@(posedge i_clk);
		mc = nx;
		i_op_valid <= $urandom_range(0, 7) != 0;
		i_use_imm <= md == 1;
		i_set_flags <= $urandom_range(0, 3) != 0;
		i_logic_class <= md != 2 || $urandom_range(0, 1);
		i_imm_byte <= 8'($urandom);
		i_imm_form <= 2'($urandom);
		i_imm_lsl <= $urandom_range(0, 3) ? 5'($urandom) : 5'h00;
		i_shift_source_reg <= $urandom;
		i_shift_kind <= 3'($urandom);
		i_shift_amt <= $urandom_range(0, 1) ? 8'(amts[$urandom_range(0, 7)]) : 8'($urandom);
		i_amt_is_imm <= 1'($urandom);
		i_pc_write <= md == 3 || $urandom_range(0, 3) == 0;
		i_pc_target <= $urandom;
		@(negedge i_clk);
		case (i_imm_form)
			2'h0: e[31:0] = 32'(i_imm_byte) << i_imm_lsl;
			2'h1: e[31:0] = {2{8'h00, i_imm_byte}};
			2'h2: e[31:0] = {2{i_imm_byte, 8'h00}};
			default: e[31:0] = {4{i_imm_byte}};
		endcase
		e[32] = e[31];
		u = i_imm_form == 2'h0 && e[31:0] > 32'h000000FF;
		if (!i_use_imm)
			e = shf(i_shift_source_reg, i_shift_kind, i_shift_amt, mc);
		if (!i_use_imm)
			u = i_shift_kind == 3'h4 || i_shift_amt != 8'h00;
		g = u & i_op_valid & i_set_flags & i_logic_class;
		if (i_op_valid)
			chk("operand", o_flexible_second_input, e[31:0]);
		// carry-out shows the shifter bit whenever the shift moves carry, flag update or not
		chk("carry_out", o_shift_carry, u ? e[32] : mc);
		chk("carry_upd", o_shift_carry_upd, g);
		chk("carry_flag", o_carry_flag, mc);
		chk("isa_fault", o_isa_fault, i_pc_write & ~i_pc_target[0]);
		chk("pc_addr", o_pc_addr, {i_pc_target[31:1], 1'b0});
		lim = (i_shift_kind == 3'h1 || i_shift_kind == 3'h2) ? 32 : 31;
		if (!i_op_valid || i_use_imm || !i_amt_is_imm || i_shift_kind == 3'h4)
			chk("illegal", o_amt_illegal, 1'b0);
		else if (i_shift_kind < 3'h4)
			chk("illegal", o_amt_illegal, (i_shift_kind != 3'h0 && i_shift_amt == 8'h00) || i_shift_amt > lim);
		nx = g ? e[32] : (i_alu_carry_we ? i_alu_carry : mc);
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			end_sim();
		end
	end
	initial
	begin
		{i_op_valid, i_use_imm, i_set_flags, i_logic_class, i_amt_is_imm, i_pc_write} = 6'h00;
		{i_imm_byte, i_shift_amt, i_imm_form, i_imm_lsl, i_shift_kind} = 26'h0;
		{i_shift_source_reg, i_pc_target} = 64'h0;
		i_rst_b = 1'b0;
		nx = 1'b0;
		void'($urandom(32'h26F3));
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int md = 0; md < 4; md++)
		begin
			repeat (1500) step(md);
			$display("test %0d done", md);
		end
		end_sim();
	end
endmodule // tb
`default_nettype wire
